/* logic/cam_stats.sv */
//////////////////////////////////////////////////////////////////////////////
// Function
// - 32 entries of 48 bits, high word full
// - Low word bits 15:0, upper bits zero
// - First octet most significant in packing
// - Count good transmitted frames
// - Count all transmitted frames
// - Count good received frames
// - Count all received frames
// - Count good relays second to first
// - Count all relays second to first
// - Counters saturate at all ones
// - Read returns value then clears counter
// - Counter writes are ignored
// - Four reference conditions per entry gate lookup
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module cam_stats
  import cam_stats_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Register port.
  input  wire logic [11:0]   addr,
  input  wire logic [31:0]   wr_data,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output logic      [31:0]   rd_data,
  // Frame events from the first port and the relay path.
  input  frame_events_t      events,
  // Lookup request and answer.
  input  lookup_req_t        lookup_req,
  output lookup_rsp_t        lookup_rsp,
  // Table update status.
  output logic               table_write_pending
);

  typedef struct packed {
    logic [1:0]        rd_sel;
    logic [31:0]       rd_word;
    logic [31:0]       stage_high;
    logic              pending;
    logic [4:0]        commit_idx;
    logic [47:0]       commit_addr;
    logic [31:0][3:0]  cond;
    logic [5:0][31:0]  cnt;
    scan_state_t       fsm;
    logic [5:0]        scan_idx;
    logic              probe;
    logic [4:0]        probe_idx;
    logic [47:0]       key;
    logic [1:0]        key_cond;
    lookup_rsp_t       rsp;
  } state_t;

  state_t      state_reg;
  state_t      state_next;
  logic [47:0] mem_q;
  logic [5:0]  ev;
  logic [5:0]  cnt_rd;
  logic        tab_rd;
  logic        low_wr;
  logic        match;
  logic [4:0]  mem_raddr;

  //////////////////////////////////////////////////////////////////////////
  // Decode and event vector.

  assign tab_rd = rd_en && (addr[11:8] == 4'h0);
  assign low_wr = wr_en && (addr[11:7] == LOW_WORD_BASE[11:7]);
  assign mem_raddr = tab_rd ? addr[6:2] : state_reg.scan_idx[4:0];
  assign match = (mem_q == state_reg.key) &&
                 state_reg.cond[state_reg.probe_idx][state_reg.key_cond];

  always_comb begin
    ev[CNT_TX_GOOD]    = events.tx_done && !events.tx_err;
    ev[CNT_TX_TOTAL]   = events.tx_done;
    ev[CNT_RX_GOOD]    = events.rx_done && !events.rx_err;
    ev[CNT_RX_TOTAL]   = events.rx_done;
    ev[CNT_RELAY_GOOD] = events.relay_done && !events.relay_err;
    ev[CNT_RELAY_TOT]  = events.relay_done;
  end

  for (genvar i = 0; i < COUNTERS; i++) begin : g_cnt_rd
    assign cnt_rd[i] = rd_en &&
                       (addr == COUNT_BASE + 12'(4 * i));
  end

  //////////////////////////////////////////////////////////////////////////
  // Entry storage.

  addr_table_mem u_mem (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .we      (state_reg.pending),
    .waddr   (state_reg.commit_idx),
    .wdata   (state_reg.commit_addr),
    .raddr   (mem_raddr),
    .rdata   (mem_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    state_next = state_reg;
    state_next.rsp.done = 1'b0;
    state_next.probe = 1'b0;

    // Commit takes exactly one cycle after the low word lands.
    state_next.pending = 1'b0;
    if (wr_en && addr[11:7] == HIGH_WORD_BASE[11:7]) begin
      state_next.stage_high = wr_data;
    end
    if (low_wr) begin
      state_next.pending = 1'b1;
      state_next.commit_idx = addr[6:2];
      state_next.commit_addr = {state_reg.stage_high,
                                wr_data[LOW_BITS-1:0]};
    end

    // Reference conditions, eight entries per register.
    for (int k = 0; k < ENTRIES; k++) begin
      if (wr_en && addr == COND_BASE + 12'(4 * (k / COND_PER_REG))) begin
        state_next.cond[k] =
          wr_data[4 * (7 - k % COND_PER_REG) +: 4];
      end
    end

    // Counters: the read sees the old value, the event is not lost.
    // No write term reaches them, so bus writes leave them alone.
    for (int i = 0; i < COUNTERS; i++) begin
      if (cnt_rd[i]) begin
        state_next.cnt[i] = ev[i] ? 32'h00000001 : WORD_RESET;
      end else if (ev[i] && state_reg.cnt[i] != COUNT_MAX) begin
        state_next.cnt[i] = state_reg.cnt[i] + 32'h00000001;
      end
    end

    // Read capture; table words come out of the memory register.
    if (rd_en) begin
      state_next.rd_sel = SEL_WORD;
      state_next.rd_word = WORD_RESET;
      if (tab_rd) begin
        state_next.rd_sel = addr[7] ? SEL_LOW : SEL_HIGH;
      end
      for (int i = 0; i < COUNTERS; i++) begin
        if (cnt_rd[i]) begin
          state_next.rd_word = state_reg.cnt[i];
        end
      end
      if (addr == STATUS_ADDR) begin
        state_next.rd_word[PENDING_BIT] = state_reg.pending;
      end
      for (int k = 0; k < ENTRIES; k++) begin
        if (addr == COND_BASE + 12'(4 * (k / COND_PER_REG))) begin
          state_next.rd_word[4 * (7 - k % COND_PER_REG) +: 4] =
            state_reg.cond[k];
        end
      end
    end

    // Lookup scan; bus reads of the table take the read port first.
    unique case (state_reg.fsm)
      SCAN_IDLE: begin
        if (lookup_req.valid) begin
          state_next.fsm = SCAN_RUN;
          state_next.key = lookup_req.key;
          state_next.key_cond = lookup_req.cond;
          state_next.scan_idx = 6'h00;
        end
      end
      SCAN_RUN: begin
        if (state_reg.probe &&
            (match || state_reg.probe_idx == LAST_ENTRY)) begin
          state_next.fsm = SCAN_IDLE;
          state_next.rsp.done = 1'b1;
          state_next.rsp.hit = match;
          state_next.rsp.index = state_reg.probe_idx;
        end else if (!tab_rd && !state_reg.scan_idx[5]) begin
          state_next.probe = 1'b1;
          state_next.probe_idx = state_reg.scan_idx[4:0];
          state_next.scan_idx = state_reg.scan_idx + 6'h01;
        end else if (state_reg.probe) begin
          // A stolen cycle leaves the earlier probe already compared.
          state_next.probe = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs. Table reads mux two registers so no wait state is needed.

  always_comb begin
    unique case (state_reg.rd_sel)
      SEL_HIGH: rd_data = mem_q[47:16];
      SEL_LOW:  rd_data = {16'h0000, mem_q[15:0]};
      default:  rd_data = state_reg.rd_word;
    endcase
  end

  assign lookup_rsp = state_reg.rsp;
  assign table_write_pending = state_reg.pending;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // One set of counter checks per slot, so every register is covered.
  for (genvar i = 0; i < COUNTERS; i++) begin : g_cnt_chk
    sat_hold_a: assert property (
      ce && state_reg.cnt[i] == COUNT_MAX && !cnt_rd[i]
      |=> state_reg.cnt[i] == COUNT_MAX)
      else $error("saturated counter moved");

    clear_read_a: assert property (
      ce && cnt_rd[i] && !ev[i]
      |=> state_reg.cnt[i] == WORD_RESET
          && rd_data == $past(state_reg.cnt[i]))
      else $error("clearing read failed");

    read_event_a: assert property (
      ce && cnt_rd[i] && ev[i]
      |=> state_reg.cnt[i] == 32'h00000001
          && rd_data == $past(state_reg.cnt[i]))
      else $error("event lost during clearing read");

    count_step_a: assert property (
      ce && ev[i] && !cnt_rd[i] && state_reg.cnt[i] != COUNT_MAX
      |=> state_reg.cnt[i] == $past(state_reg.cnt[i]) + 32'h00000001)
      else $error("counter did not count");

    write_ignored_a: assert property (
      ce && wr_en && addr == COUNT_BASE + 12'(4 * i) && !ev[i]
      |=> state_reg.cnt[i] == $past(state_reg.cnt[i]))
      else $error("counter changed on write");
  end

  pending_set_a: assert property (
    ce && low_wr |=> table_write_pending ##1 (!table_write_pending
    || !$past(ce) || $past(low_wr)))
    else $error("pending flag sequence wrong");

  pending_clear_a: assert property (
    ce && !low_wr |=> !table_write_pending)
    else $error("pending flag stuck");

  low_zero_a: assert property (
    ce && rd_en && addr[11:7] == LOW_WORD_BASE[11:7]
    |=> rd_data[31:16] == 16'h0000)
    else $error("low word upper bits not zero");

  status_read_a: assert property (
    ce && rd_en && addr == STATUS_ADDR
    |=> rd_data == {31'h0, $past(table_write_pending)})
    else $error("status word wrong");

  stage_high_a: assert property (
    ce && wr_en && addr[11:7] == HIGH_WORD_BASE[11:7]
    |=> state_reg.stage_high == $past(wr_data))
    else $error("high word not staged");

  commit_order_a: assert property (
    ce && low_wr
    |=> state_reg.commit_addr[47:16] == $past(state_reg.stage_high)
        && state_reg.commit_addr[15:0] == $past(wr_data[15:0]))
    else $error("address packed in wrong order");

  done_pulse_a: assert property (
    ce && lookup_rsp.done |=> !lookup_rsp.done)
    else $error("lookup done longer than one cycle");

  cond_gate_a: assert property (
    ce && state_reg.probe
    && !state_reg.cond[state_reg.probe_idx][state_reg.key_cond]
    |=> !lookup_rsp.done || !lookup_rsp.hit)
    else $error("hit on entry without its condition");

  first_hit_a: assert property (
    ce && state_reg.probe && match
    |=> lookup_rsp.done && lookup_rsp.hit
        && lookup_rsp.index == $past(state_reg.probe_idx))
    else $error("matching entry not reported");

  miss_end_a: assert property (
    ce && state_reg.probe && !match && state_reg.probe_idx == LAST_ENTRY
    |=> lookup_rsp.done && !lookup_rsp.hit)
    else $error("miss not reported after last entry");

endmodule

/* logic/cam_stats_pkg.sv */
package cam_stats_pkg;

  // Register map, byte addresses on a 12-bit address port.
  localparam logic [11:0] HIGH_WORD_BASE = 12'h000;
  localparam logic [11:0] LOW_WORD_BASE  = 12'h080;
  localparam logic [11:0] COUNT_BASE     = 12'h100;
  localparam logic [11:0] STATUS_ADDR    = 12'h118;
  localparam logic [11:0] COND_BASE      = 12'h120;

  // Table and counter geometry.
  localparam int          ENTRIES        = 32;
  localparam int          ADDR_BITS      = 48;
  localparam int          COUNTERS       = 6;
  localparam int          COND_PER_REG   = 8;
  localparam logic [4:0]  LAST_ENTRY     = 5'h1f;

  // Field layout and reset values.
  localparam int          LOW_BITS       = 16;
  localparam int          PENDING_BIT    = 0;
  localparam logic [31:0] COUNT_MAX      = 32'hffffffff;
  localparam logic [31:0] WORD_RESET     = 32'h00000000;

  // Counter slots, in register order.
  localparam int          CNT_TX_GOOD    = 0;
  localparam int          CNT_TX_TOTAL   = 1;
  localparam int          CNT_RX_GOOD    = 2;
  localparam int          CNT_RX_TOTAL   = 3;
  localparam int          CNT_RELAY_GOOD = 4;
  localparam int          CNT_RELAY_TOT  = 5;

  // Reference conditions, as bit numbers inside one entry's nibble.
  localparam logic [1:0]  COND_P0_RX     = 2'h3;
  localparam logic [1:0]  COND_0TO1      = 2'h2;
  localparam logic [1:0]  COND_P1_RX     = 2'h1;
  localparam logic [1:0]  COND_1TO0      = 2'h0;

  // Source of the read data in the cycle after a read strobe.
  localparam logic [1:0]  SEL_WORD       = 2'h0;
  localparam logic [1:0]  SEL_HIGH       = 2'h1;
  localparam logic [1:0]  SEL_LOW        = 2'h2;

  typedef enum logic {
    SCAN_IDLE = 1'b0,
    SCAN_RUN  = 1'b1
  } scan_state_t;

  typedef struct packed {
    logic tx_done;
    logic tx_err;
    logic rx_done;
    logic rx_err;
    logic relay_done;
    logic relay_err;
  } frame_events_t;

  typedef struct packed {
    logic        valid;
    logic [47:0] key;
    logic [1:0]  cond;
  } lookup_req_t;

  typedef struct packed {
    logic       done;
    logic       hit;
    logic [4:0] index;
  } lookup_rsp_t;

endpackage

/* logic/addr_table_mem.sv */
`timescale 1ns/1ps
module addr_table_mem
  import cam_stats_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Write port.
  input  wire logic        we,
  input  wire logic [4:0]  waddr,
  input  wire logic [47:0] wdata,
  // Read port, data one cycle later.
  input  wire logic [4:0]  raddr,
  output logic      [47:0] rdata
);

  logic [47:0] mem [ENTRIES];

  // Every entry resets to zero so readback is defined before programming.
  // This costs flops instead of a plain RAM, which the table size allows.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int e = 0; e < ENTRIES; e++) begin
        mem[e] <= 48'h0;
      end
    end else if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 48'h0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule

/* testbench/frame_source.sv */
`timescale 1ns/1ps
module frame_source
  import cam_stats_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Command from the bench.
  input  wire logic       go,
  input  frame_events_t   pattern,
  input  wire logic [3:0] count,
  input  wire logic [1:0] gap,
  // Frame ends toward the block.
  output frame_events_t   events,
  output logic            busy
);
  frame_events_t pat_reg;
  logic [3:0]    left_reg;
  logic [1:0]    wait_reg;

  assign busy = left_reg != 4'h0;

  // Each frame end is a single-cycle pulse; a longer one would count twice.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pat_reg <= '0;
      left_reg <= 4'h0;
      wait_reg <= 2'h0;
      events <= '0;
    end else begin
      events <= '0;
      if (go && left_reg == 4'h0) begin
        pat_reg <= pattern;
        left_reg <= count;
        wait_reg <= 2'h0;
      end else if (left_reg != 4'h0) begin
        if (wait_reg == 2'h0) begin
          events <= pat_reg;
          left_reg <= left_reg - 4'h1;
          wait_reg <= gap;
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end
    end
  end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import cam_stats_pkg::*;
;
  logic          sys_clk;
  logic          rst_n;
  logic          ce;
  logic          wr_en;
  logic          rd_en;
  logic          go;
  logic          busy;
  logic          table_write_pending;
  logic [11:0]   addr;
  logic [31:0]   wr_data;
  logic [31:0]   rd_data;
  logic [31:0]   got;
  logic [3:0]    count;
  logic [1:0]    gap;
  frame_events_t events;
  frame_events_t pattern;
  lookup_req_t   lookup_req;
  lookup_rsp_t   lookup_rsp;
  int            n_fail;
  int            compares;
  logic [31:0]   exp_cnt [6] = '{32'h3, 32'h5, 32'h4, 32'h6, 32'h3, 32'h5};

  cam_stats dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .events(events), .lookup_req(lookup_req),
    .lookup_rsp(lookup_rsp), .table_write_pending(table_write_pending));

  frame_source model_u (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
    .pattern(pattern), .count(count), .gap(gap), .events(events),
    .busy(busy));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp,
                          input logic seen);
    chk_word(what, {31'h0, exp}, {31'h0, seen});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    got = rd_data;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    rd(a);
    chk_word(what, exp, got);
  endtask

  task automatic start(input frame_events_t p, input logic [3:0] n,
                       input logic [1:0] g);
    @(posedge sys_clk);
    pattern <= p;
    count <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask

  task automatic send(input frame_events_t p, input logic [3:0] n,
                      input logic [1:0] g);
    int i;
    start(p, n, g);
    i = 0;
    do begin
      @(posedge sys_clk);
      #1;
      i++;
    end while (busy === 1'b1 && i < 100);
  endtask

  task automatic look(input logic [47:0] k, input logic [1:0] c,
                      input logic h, input logic [4:0] x);
    int i;
    @(posedge sys_clk);
    lookup_req <= '{1'b1, k, c};
    @(posedge sys_clk);
    lookup_req.valid <= 1'b0;
    i = 0;
    while (lookup_rsp.done !== 1'b1 && i < 60) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk_flag("lookup done", 1'b1, lookup_rsp.done);
    chk_flag("lookup hit", h, lookup_rsp.hit);
    if (h)
      chk_word("lookup index", {27'h0, x}, {27'h0, lookup_rsp.index});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    go = 1'b0;
    addr = 12'h000;
    wr_data = 32'h0;
    pattern = '0;
    count = 4'h0;
    gap = 2'h0;
    lookup_req = '0;
    n_fail = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk("high word", HIGH_WORD_BASE, WORD_RESET);
    rd_chk("status", STATUS_ADDR, WORD_RESET);
    for (int i = 0; i < COUNTERS; i++)
      rd_chk("counter reset", COUNT_BASE + 12'(4 * i), WORD_RESET);
    rd_chk("pending idle", STATUS_ADDR, WORD_RESET);
    wr(HIGH_WORD_BASE + 12'h014, 32'h01234567);
    wr(LOW_WORD_BASE + 12'h014, 32'h000089ab);
    #1;
    chk_flag("pending", 1'b1, table_write_pending);
    @(posedge sys_clk);
    #1;
    chk_flag("pending", 1'b0, table_write_pending);
    rd_chk("high word", HIGH_WORD_BASE + 12'h014, 32'h01234567);
    rd_chk("low word", LOW_WORD_BASE + 12'h014, 32'h000089ab);
    wr(COND_BASE, 32'h00000a00);
    rd_chk("conditions", COND_BASE, 32'h00000a00);
    look(48'h0123456789ab, COND_P0_RX, 1'b1, 5'h05);
    look(48'h0123456789ab, COND_P1_RX, 1'b1, 5'h05);
    look(48'h0123456789ab, COND_0TO1, 1'b0, 5'h00);
    look(48'h0123456789ab, COND_1TO0, 1'b0, 5'h00);
    look(48'h0123456789aa, COND_P0_RX, 1'b0, 5'h00);
    rd_chk("unmapped", 12'hffc, WORD_RESET);
    send(6'b101010, 4'h3, 2'h0);
    send(6'b111111, 4'h2, 2'h2);
    send(6'b001000, 4'h1, 2'h0);
    wr(COUNT_BASE, 32'h00000055);
    for (int i = 0; i < COUNTERS; i++)
      rd_chk("counter", COUNT_BASE + 12'(4 * i), exp_cnt[i]);
    for (int i = 0; i < COUNTERS; i++)
      rd_chk("cleared", COUNT_BASE + 12'(4 * i), WORD_RESET);
    // The read below lands in the same cycle as the model's pulse.
    start(6'b100000, 4'h1, 2'h0);
    rd(COUNT_BASE);
    chk_word("read with event", WORD_RESET, got);
    rd_chk("after event", COUNT_BASE, 32'h00000001);
    // With the enable low the block must ignore a frame end.
    @(posedge sys_clk);
    ce <= 1'b0;
    send(6'b100000, 4'h1, 2'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd_chk("frozen count", COUNT_BASE, WORD_RESET);
    // Saturation needs 2^32 frames, so only the design's assertion sees it.
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end
endmodule
